// ==== design/cssr_ctrl.sv ====
// Purpose: clock source decode, sleep mode control and reset pin handling
// Assumes: AXI4-Lite slave on aclk, one clock, synchronous aresetn
// Notes: clock gates are enables to downstream logic, not real gated clocks
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module cssr_ctrl #(
    parameter int unsigned RC_DIV = cssr_pkg::INT_RC_DIV,
    parameter int unsigned RST_CYC = cssr_pkg::RESET_MIN_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core events
    input wire logic sleep_instr,
    input wire logic wake_irq,
    // External reset pin
    input wire logic ext_reset_n,
    // Clock source and enables
    output logic [4:0] clk_src_onehot,
    output logic int_rc_tick,
    output logic osc_run,
    output logic cpu_clk_en,
    output logic mem_clk_en,
    output logic timer_clk_en,
    output logic spi_clk_en,
    output logic irq_clk_en,
    output logic async_timer_en,
    output logic adc_clk_en,
    output logic io_clk_en,
    // Reset and pins
    output logic sys_reset,
    output logic port_hiz
);
    // Field decode shared by status and source outputs
    function automatic cssr_pkg::cssr_src_t src_decode(input logic [3:0] f);
        // Programmed bits read zero, so low codes mean programmed fuses
        if (f >= 4'hA) src_decode = cssr_pkg::CSSR_SRC_XTAL;
        else if (f >= 4'h8) src_decode = cssr_pkg::CSSR_SRC_LFXTAL;
        else if (f >= 4'h5) src_decode = cssr_pkg::CSSR_SRC_EXTRC;
        else if (f >= 4'h2) src_decode = cssr_pkg::CSSR_SRC_INTRC;
        else src_decode = cssr_pkg::CSSR_SRC_EXTCLK;
    endfunction : src_decode

    logic reset_req;
    logic pin_hiz;

    // Reset pin qualification
    cssr_reset_filter #(
        .MIN_CYC(RST_CYC)
    ) u_rst (
        .aclk(aclk),
        .aresetn(aresetn),
        .ext_reset_n(ext_reset_n),
        .reset_req(reset_req),
        .port_hiz(pin_hiz)
    );

    // Register state
    logic [3:0] clk_src_select;
    logic [3:0] next_clk_src_select;
    cssr_pkg::cssr_sleep_t sleep_mode;
    cssr_pkg::cssr_sleep_t next_sleep_mode;
    logic sleep_en;
    logic next_sleep_en;
    logic asleep;
    logic next_asleep;
    // Bus state
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic do_write;
    cssr_pkg::cssr_src_t src;

    assign src = src_decode(clk_src_select);
    assign do_write = aw_held && w_held && !bvalid;

    // Write channel: address and data taken in either order
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_clk_src_select = clk_src_select;
        next_sleep_mode = sleep_mode;
        next_sleep_en = sleep_en;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = cssr_pkg::RESP_OKAY;
            case ({aw_addr[7:2], 2'b00})
                cssr_pkg::OFS_CLKCFG: begin
                    if (w_strb[0]) begin
                        next_clk_src_select = w_data[3:0];
                    end
                end
                cssr_pkg::OFS_SLEEP: begin
                    if (w_strb[0]) begin
                        // Two-bit field: always exactly one mode held
                        next_sleep_mode = cssr_pkg::cssr_sleep_t'(
                            w_data[cssr_pkg::SLEEP_MODE_LSB +: 2]);
                        next_sleep_en = w_data[cssr_pkg::SLEEP_EN_BIT];
                    end
                end
                cssr_pkg::OFS_STATUS: ; // Read only, write ignored
                default: next_bresp = cssr_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Read channel, one read in flight
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = cssr_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                cssr_pkg::OFS_CLKCFG: next_rdata[3:0] = clk_src_select;
                cssr_pkg::OFS_SLEEP: begin
                    next_rdata[cssr_pkg::SLEEP_MODE_LSB +: 2] = sleep_mode;
                    next_rdata[cssr_pkg::SLEEP_EN_BIT] = sleep_en;
                end
                cssr_pkg::OFS_STATUS: begin
                    next_rdata[cssr_pkg::STAT_SRC_LSB +: 3] = src;
                    next_rdata[cssr_pkg::STAT_ASLEEP_BIT] = asleep;
                    next_rdata[cssr_pkg::STAT_MODE_LSB +: 2] = sleep_mode;
                    next_rdata[cssr_pkg::STAT_PORTZ_BIT] = port_hiz;
                end
                default: next_rresp = cssr_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Sleep state: enter on the instruction, leave on wake or reset
    always_comb begin
        next_asleep = asleep;
        if (!asleep && sleep_instr && sleep_en) begin
            next_asleep = 1'b1;
        end else if (asleep && wake_irq) begin
            next_asleep = 1'b0;
        end
    end

    // Internal RC tick divider
    localparam int unsigned DW = $clog2(RC_DIV + 1);
    logic [DW-1:0] rc_cnt, next_rc_cnt;
    logic next_rc_tick;
    always_comb begin
        next_rc_cnt = rc_cnt + DW'(1);
        next_rc_tick = 1'b0;
        if (rc_cnt >= DW'(RC_DIV - 1)) begin
            next_rc_cnt = '0;
            // Tick only when the internal RC is the chosen source
            next_rc_tick = (src == cssr_pkg::CSSR_SRC_INTRC);
        end
    end

    // Enables per mode; awake means all run
    logic n_osc, n_cpu, n_mem, n_tmr, n_spi, n_irq, n_atmr, n_adc, n_io;
    always_comb begin
        n_osc = 1'b1;
        n_cpu = 1'b1;
        n_mem = 1'b1;
        n_tmr = 1'b1;
        n_spi = 1'b1;
        n_irq = 1'b1;
        n_atmr = 1'b1;
        n_adc = 1'b1;
        n_io = 1'b1;
        if (next_asleep) begin
            n_cpu = 1'b0;
            case (sleep_mode)
                cssr_pkg::CSSR_SLP_IDLE: begin
                    n_adc = 1'b1;
                end
                cssr_pkg::CSSR_SLP_ADCNR: begin
                    {n_mem, n_tmr, n_spi, n_io} = 4'h0;
                    n_irq = 1'b1; // Wake logic must still see events
                end
                cssr_pkg::CSSR_SLP_PWRDN: begin
                    {n_osc, n_mem, n_tmr, n_spi, n_io} = 5'h00;
                    {n_atmr, n_adc} = 2'b00;
                end
                cssr_pkg::CSSR_SLP_PWRSAVE: begin
                    {n_osc, n_mem, n_tmr, n_spi, n_io} = 5'h00;
                    n_adc = 1'b0;
                    n_atmr = 1'b1;
                end
                default: n_cpu = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            clk_src_select <= cssr_pkg::CLKSRC_DEFAULT;
            sleep_mode <= cssr_pkg::CSSR_SLP_IDLE;
            sleep_en <= 1'b0;
            asleep <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= cssr_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= cssr_pkg::RESP_OKAY;
            rdata <= 32'h0000_0000;
            rc_cnt <= '0;
            int_rc_tick <= 1'b0;
            {osc_run, cpu_clk_en, mem_clk_en, timer_clk_en} <= 4'h0;
            {spi_clk_en, irq_clk_en, async_timer_en} <= 3'h0;
            {adc_clk_en, io_clk_en} <= 2'h0;
            clk_src_onehot <= 5'h00;
        end else begin
            clk_src_select <= next_clk_src_select;
            sleep_mode <= next_sleep_mode;
            sleep_en <= next_sleep_en;
            asleep <= next_asleep;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            rc_cnt <= next_rc_cnt;
            int_rc_tick <= next_rc_tick;
            osc_run <= n_osc;
            cpu_clk_en <= n_cpu;
            mem_clk_en <= n_mem;
            timer_clk_en <= n_tmr;
            spi_clk_en <= n_spi;
            irq_clk_en <= n_irq;
            async_timer_en <= n_atmr;
            adc_clk_en <= n_adc;
            io_clk_en <= n_io;
            clk_src_onehot <= 5'(5'h01 << src_decode(next_clk_src_select));
        end
    end

    // Bus outputs: ready while the holding slot is empty; a pin reset
    // closes the slots from its second edge; a request still held or taken on its first edge is lost
    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !next_aw_held;
            s_axi_wready <= !next_w_held;
            s_axi_arready <= !next_rvalid;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    // Reset outputs pass straight from the pin so no clock is needed
    assign sys_reset = reset_req;
    assign port_hiz = pin_hiz;
endmodule : cssr_ctrl

// ==== design/cssr_pkg.sv ====
// Purpose: shared constants for the clock select, sleep and reset control
// Assumes: 32-bit AXI4-Lite register access, 20 MHz system clock
// Notes: offsets are byte addresses of aligned words
package cssr_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RESET_MIN_NS = 500;
    // Least time rounds up to whole cycles
    localparam int unsigned RESET_MIN_CYC =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INT_RC_HZ = 1_000_000;
    localparam int unsigned INT_RC_DIV = CLK_HZ / INT_RC_HZ;

    // Register offsets
    localparam logic [7:0] OFS_CLKCFG = 8'h00;
    localparam logic [7:0] OFS_SLEEP = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // Field positions
    localparam int unsigned SLEEP_MODE_LSB = 0;
    localparam int unsigned SLEEP_EN_BIT = 2;
    localparam int unsigned STAT_SRC_LSB = 0;
    localparam int unsigned STAT_ASLEEP_BIT = 4;
    localparam int unsigned STAT_MODE_LSB = 5;
    localparam int unsigned STAT_PORTZ_BIT = 7;

    // Reset values; unprogrammed bits read one, 0010 selects internal RC
    localparam logic [3:0] CLKSRC_DEFAULT = 4'h2;
    localparam logic [31:0] SLEEP_RESET = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        CSSR_SRC_XTAL,
        CSSR_SRC_LFXTAL,
        CSSR_SRC_EXTRC,
        CSSR_SRC_INTRC,
        CSSR_SRC_EXTCLK
    } cssr_src_t;

    typedef enum logic [1:0] {
        CSSR_SLP_IDLE,
        CSSR_SLP_ADCNR,
        CSSR_SLP_PWRDN,
        CSSR_SLP_PWRSAVE
    } cssr_sleep_t;
endpackage : cssr_pkg

// ==== design/cssr_reset_filter.sv ====
// Purpose: qualify the external reset pin and hold ports in high impedance
// Assumes: pin is synchronous to aclk; clockless path is combinational
// Notes: pulses of at least the minimum width always give a reset
`timescale 1ns/1ps
module cssr_reset_filter #(
    parameter int unsigned MIN_CYC = cssr_pkg::RESET_MIN_CYC
) (
    // Clock and bus reset
    input wire logic aclk,
    input wire logic aresetn,
    // External reset pin
    input wire logic ext_reset_n,
    // Qualified result
    output logic reset_req,
    output logic port_hiz
);
    localparam int unsigned CW = $clog2(MIN_CYC + 1);
    logic [CW-1:0] low_cnt;
    logic [CW-1:0] next_low_cnt;
    logic held;
    logic next_held;

    // Count low cycles; release clears the count
    always_comb begin
        next_low_cnt = low_cnt;
        next_held = held;
        if (ext_reset_n) begin
            next_low_cnt = '0;
            next_held = 1'b0;
        end else if (low_cnt < CW'(MIN_CYC)) begin
            next_low_cnt = low_cnt + CW'(1);
        end else begin
            next_held = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_cnt <= '0;
            held <= 1'b0;
        end else begin
            low_cnt <= next_low_cnt;
            held <= next_held;
        end
    end

    // Pin low reaches the reset directly, so no clock is needed
    assign reset_req = held | ~ext_reset_n;
    assign port_hiz = ~ext_reset_n | ~aresetn;
endmodule : cssr_reset_filter

// ==== verif/cssr_ctrl_checker.sv ====
// Purpose: port-level checks of source decode, sleep and reset pin
// Assumes: one clock domain, sync active-low aresetn
// Notes: bound to every cssr_ctrl instance
`timescale 1ns/1ps
module cssr_ctrl_checker #(
    parameter int unsigned RC_DIV = 20,
    parameter int unsigned RST_CYC = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Events and pin
    input wire logic sleep_instr,
    input wire logic wake_irq,
    input wire logic ext_reset_n,
    // Outputs watched
    input wire logic [4:0] clk_src_onehot,
    input wire logic int_rc_tick,
    input wire logic osc_run,
    input wire logic cpu_clk_en,
    input wire logic mem_clk_en,
    input wire logic timer_clk_en,
    input wire logic spi_clk_en,
    input wire logic irq_clk_en,
    input wire logic async_timer_en,
    input wire logic adc_clk_en,
    input wire logic io_clk_en,
    input wire logic sys_reset,
    input wire logic port_hiz
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] rc_run;
    logic [7:0] next_rc_run;
    // Cycles with internal RC held; a source change or a low reset pin restarts the count
    always_comb begin
        next_rc_run = rc_run;
        if (!clk_src_onehot[3] || !ext_reset_n) next_rc_run = 8'h00;
        else if (rc_run != 8'hff) next_rc_run = rc_run + 8'h01;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) rc_run <= 8'h00;
        else rc_run <= next_rc_run;
    end
    sequence s_long_low;
        !ext_reset_n [*8] ##1 !ext_reset_n [*3];
    endsequence
    a_hiz_on_pin: assert property (!ext_reset_n |-> port_hiz)
        else $error("port_hiz low while reset pin low");
    a_reset_on_pin: assert property (!ext_reset_n |-> sys_reset)
        else $error("sys_reset low while reset pin low");
    a_pin_latch: assert property (s_long_low ##1 ext_reset_n |-> sys_reset)
        else $error("long reset pulse not held");
    a_tick_only_rc: assert property (int_rc_tick |->
        clk_src_onehot[3] || $past(clk_src_onehot[3]))
        else $error("rc tick without internal rc");
    a_tick_period: assert property (int_rc_tick ##RC_DIV
        (rc_run > RC_DIV) |-> int_rc_tick)
        else $error("rc tick period wrong");
    a_sleep_entry: assert property ($fell(cpu_clk_en) && !sys_reset
        && !$past(sys_reset) |-> $past(sleep_instr))
        else $error("cpu clock stopped without sleep");
    a_wake_irq: assert property (!cpu_clk_en && wake_irq && ext_reset_n
        && !sys_reset |-> ##[1:2] cpu_clk_en)
        else $error("interrupt did not wake");
    a_idle_keeps: assert property (!cpu_clk_en && mem_clk_en |->
        timer_clk_en && spi_clk_en && irq_clk_en)
        else $error("idle stopped a live clock");
    a_osc_off_all: assert property (!osc_run |-> !cpu_clk_en
        && !mem_clk_en && !adc_clk_en && !io_clk_en)
        else $error("clock on with oscillator halted");
    a_adc_keeps: assert property (!cpu_clk_en && !io_clk_en && osc_run
        |-> adc_clk_en && async_timer_en && !mem_clk_en)
        else $error("adc noise mode enables wrong");
endmodule : cssr_ctrl_checker
bind cssr_ctrl cssr_ctrl_checker #(.RC_DIV(RC_DIV), .RST_CYC(RST_CYC)) chk_i (
    .aclk, .aresetn, .sleep_instr, .wake_irq, .ext_reset_n, .clk_src_onehot,
    .int_rc_tick, .osc_run, .cpu_clk_en, .mem_clk_en, .timer_clk_en,
    .spi_clk_en, .irq_clk_en, .async_timer_en, .adc_clk_en, .io_clk_en,
    .sys_reset, .port_hiz);

// ==== verif/cssr_reset_src.sv ====
// Purpose: far-side driver of the external reset pin
// Assumes: pin has a pull-up, so released means high
// Notes: pulse length is whole aclk cycles
`timescale 1ns/1ps
module cssr_reset_src (
    // Timing clock
    input wire logic aclk,
    // Reset pin
    output logic ext_reset_n
);
    initial ext_reset_n = 1'b1;
    // Low for cyc edges; short pulses are legal but need not reset
    task automatic pulse(input int cyc);
        ext_reset_n <= 1'b0;
        repeat (cyc) @(posedge aclk);
        ext_reset_n <= 1'b1;
    endtask : pulse
endmodule : cssr_reset_src

// ==== verif/test_clock_select_sleep_reset_ctrl.sv ====
// Purpose: register-driven test of source decode, sleep and reset pin
// Assumes: AXI4-Lite master tasks, 20 MHz aclk
// Notes: enables packed osc,cpu,mem,timer,spi,irq,async,adc,io
`timescale 1ns/1ps
module test_clock_select_sleep_reset_ctrl;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic sleep_instr = 1'b0, wake_irq = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_reset_n, int_rc_tick, osc_run, cpu_clk_en;
    logic mem_clk_en, timer_clk_en, spi_clk_en, irq_clk_en, async_timer_en;
    logic adc_clk_en, io_clk_en, sys_reset, port_hiz;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [4:0] clk_src_onehot;
    logic [8:0] ens;
    // Expected enables: idle, adc noise, power-down, power-save
    logic [8:0] mode_en [4] = '{9'h17f, 9'h10e, 9'h008, 9'h00c};
    int err_total = 0, num_checks = 0, n;
    assign ens = {osc_run, cpu_clk_en, mem_clk_en, timer_clk_en, spi_clk_en,
        irq_clk_en, async_timer_en, adc_clk_en, io_clk_en};
    always #25 aclk = ~aclk;
    cssr_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_instr, .wake_irq,
        .ext_reset_n, .clk_src_onehot, .int_rc_tick, .osc_run, .cpu_clk_en,
        .mem_clk_en, .timer_clk_en, .spi_clk_en, .irq_clk_en,
        .async_timer_en, .adc_clk_en, .io_clk_en, .sys_reset, .port_hiz);
    cssr_reset_src drv (.aclk, .ext_reset_n);
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic tmo();
        err_total++;
        $display("CHECK FAILED handshake timeout");
        print_verdict();
    endtask : tmo
    // Both channels offered at once, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 60; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (k == 60) tmo();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 60; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (k == 60) tmo();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdr
    // One-cycle pulse on an event input, then let enables settle
    task automatic pls(input bit slp);
        @(posedge aclk);
        if (slp) sleep_instr <= 1'b1;
        else wake_irq <= 1'b1;
        @(posedge aclk);
        sleep_instr <= 1'b0;
        wake_irq <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
    endtask : pls
    // Source class of a code; low codes are programmed bits
    function automatic int src_idx(input int c);
        if (c >= 10) return 0;
        if (c >= 8) return 1;
        if (c >= 5) return 2;
        if (c >= 2) return 3;
        return 4;
    endfunction : src_idx
    initial begin
        repeat (4) @(posedge aclk);
        #1 chk("hiz in reset", 1, port_hiz);
        @(posedge aclk);
        aresetn <= 1'b1;
        rdr(cssr_pkg::OFS_CLKCFG, rd, rsp);
        chk("clkcfg default", 2, rd);
        #1 chk("default onehot", 32'h0000_0008, clk_src_onehot);
        chk("awake enables", 9'h1ff, ens);
        // Time between two rc ticks
        for (n = 0; n < 40 && !int_rc_tick; n++) @(posedge aclk) #1;
        for (n = 1; n < 40; n++) begin
            @(posedge aclk) #1;
            if (int_rc_tick) break;
        end
        chk("rc tick period", 20, n);
        // Every source code, top down
        for (int c = 15; c >= 0; c--) begin
            wr(cssr_pkg::OFS_CLKCFG, c, rsp);
            chk("clkcfg resp", cssr_pkg::RESP_OKAY, rsp);
            rdr(cssr_pkg::OFS_STATUS, rd, rsp);
            chk("status src", src_idx(c), rd[2:0]);
            chk("onehot", 32'h1 << src_idx(c), clk_src_onehot);
        end
        wr(cssr_pkg::OFS_CLKCFG, 2, rsp);
        // Strobe off: the write is answered but leaves the field alone
        s_axi_wstrb <= 4'h0;
        wr(cssr_pkg::OFS_CLKCFG, 32'h0000_000f, rsp);
        s_axi_wstrb <= 4'hf;
        rdr(cssr_pkg::OFS_CLKCFG, rd, rsp);
        chk("strobe off", 2, rd);
        // Each sleep mode, first without enable
        for (int m = 0; m < 4; m++) begin
            wr(cssr_pkg::OFS_SLEEP, m, rsp);
            pls(1);
            chk("not enabled", 9'h1ff, ens);
            wr(cssr_pkg::OFS_SLEEP, 4 | m, rsp);
            pls(1);
            chk("mode enables", mode_en[m], ens);
            rdr(cssr_pkg::OFS_STATUS, rd, rsp);
            chk("asleep", 1, rd[4]);
            chk("mode", m, rd[6:5]);
            pls(0);
            chk("woken", 9'h1ff, ens);
        end
        rdr(8'h0c, rd, rsp);
        chk("unmapped read", cssr_pkg::RESP_SLVERR, rsp);
        wr(8'h0c, 32'h0000_0001, rsp);
        chk("unmapped write", cssr_pkg::RESP_SLVERR, rsp);
        wr(cssr_pkg::OFS_STATUS, 32'hffff_ffff, rsp);
        chk("status write", cssr_pkg::RESP_OKAY, rsp);
        // Long pin reset out of power-down
        wr(cssr_pkg::OFS_CLKCFG, 15, rsp);
        wr(cssr_pkg::OFS_SLEEP, 6, rsp);
        pls(1);
        fork
            drv.pulse(12);
            begin
                #1 chk("hiz on pin", 1, port_hiz);
                chk("reset on pin", 1, sys_reset);
            end
        join
        repeat (20) @(posedge aclk);
        #1 chk("reset wake", 9'h1ff, ens);
        rdr(cssr_pkg::OFS_CLKCFG, rd, rsp);
        chk("clkcfg after pin", 2, rd);
        // Short pulse still floats ports at once
        fork
            drv.pulse(1);
            #1 chk("hiz short pulse", 1, port_hiz);
        join
        print_verdict();
    end
endmodule : test_clock_select_sleep_reset_ctrl
